// ==== core/srb_edge.sv ====
// rising-edge detector for a block clock pin sampled on the system clock
module srb_edge (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// sampled level and its rising edge
	input wire logic level,
	output logic rise
);
	import srb_pkg::*;

	logic prev_q;

	always_ff @(posedge clk_sys) begin
		prev_q <= rst ? 1'b0 : level;
	end

	// block clock pins are slow compared with the system clock
	assign rise = level & ~prev_q;

endmodule : srb_edge

// ==== core/srb_outreg.sv ====
// data output register with optional bypass and its own clear
module srb_outreg (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic tick,
	input wire logic clr,
	input wire logic bypass,
	// data
	input wire logic [srb_pkg::SRB_ROW_W-1:0] d,
	output logic [srb_pkg::SRB_ROW_W-1:0] q
);
	import srb_pkg::*;

	logic [SRB_ROW_W-1:0] q_q;
	logic [SRB_ROW_W-1:0] q_d;

	// clear beats any load and needs no block clock edge; see RULE10
	assign q_d = clr ? '0 : ((bypass | tick) ? d : q_q); // see RULE8

	always_ff @(posedge clk_sys) begin
		q_q <= rst ? '0 : q_d; // see RULE11
	end

	assign q = q_q;

endmodule : srb_outreg

// ==== core/srb_ram.sv ====
// small simple dual-port ram block with fifo, rom and shift modes
// Overview of operation
// RULE1: holds 576 bits with parity, one write port and one read port.
// RULE2: organisations 512x1 up to 32x18, picked by configuration.
// RULE3: write and read widths may differ over the same contents.
// RULE4: modes are dual-port, single-port, fifo, rom, shift; no true dual-port.
// RULE5: contents preload from an initialization image at configuration.
// RULE6: write enable, data and address registers share one selected clock.
// RULE7: read address, read enable and output registers pick either clock (single-port and shift modes clock the read registers on the write clock).
// RULE8: only the output register may be bypassed.
// RULE9: input clear acts at once; output shows it from the next edge (a registered output here keeps its word, as the clear also drops rd_en_q).
// RULE10: output clear reaches the outputs without waiting for a clock edge.
// RULE11: after power-up the data outputs read zero.
// RULE12: user logic drives enables, clocks, clock enables and clears.
// RULE13: a read of the address being written returns the old data.
// RULE14: byte enables mask write bytes; parity bits stored as data.
module srb_ram #(
	parameter logic [srb_pkg::SRB_BITS-1:0] INIT_IMAGE = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// configuration
	input wire srb_pkg::srb_cfg_t cfg,
	// block clocks, clock enables and clears
	input wire logic clk_a,
	input wire logic clk_b,
	input wire logic ce_a,
	input wire logic ce_b,
	input wire logic clr_in,
	input wire logic clr_out,
	// write port
	input wire srb_pkg::srb_wr_t wr,
	// read port
	input wire srb_pkg::srb_rd_t rd,
	output logic [srb_pkg::SRB_ROW_W-1:0] rd_data,
	// fifo status
	output logic fifo_full,
	output logic fifo_empty
);
	import srb_pkg::*;

	// ----------------------------------------------------------------
	// block clock edges
	// ----------------------------------------------------------------
	logic rise_a;
	logic rise_b;
	logic tick_a;
	logic tick_b;
	logic wr_tick;
	logic rd_tick;
	logic out_tick;

	srb_edge u_edge_a (
		.clk_sys(clk_sys),
		.rst(rst),
		.level(clk_a),
		.rise(rise_a)
	);

	srb_edge u_edge_b (
		.clk_sys(clk_sys),
		.rst(rst),
		.level(clk_b),
		.rise(rise_b)
	);

	// each block clock is separate, with its own enable; see RULE12
	assign tick_a = rise_a & ce_a;
	assign tick_b = rise_b & ce_b;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	logic is_fifo;
	logic is_shift;
	logic is_rom;
	logic is_sp;
	logic own_rd_w;
	srb_width_t rd_w;

	// no true dual-port: only one write port exists at all; see RULE4
	assign is_fifo = cfg.mode == SRB_MODE_FIFO;
	assign is_shift = cfg.mode == SRB_MODE_SHIFT;
	assign is_rom = cfg.mode == SRB_MODE_ROM;
	assign is_sp = cfg.mode == SRB_MODE_SP;
	assign own_rd_w = cfg.mode == SRB_MODE_SDP || is_rom;
	// a separate read width only where the ports are independent
	assign rd_w = own_rd_w ? cfg.rd_width : cfg.wr_width; // see RULE3

	assign wr_tick = cfg.wr_clk == SRB_CLK_A ? tick_a : tick_b; // see RULE6
	// single-port and shift modes run the read side on the write clock
	assign rd_tick = (is_sp | is_shift) ? wr_tick
		: (cfg.rd_clk == SRB_CLK_A ? tick_a : tick_b); // see RULE7
	assign out_tick = cfg.out_clk == SRB_CLK_A ? tick_a : tick_b; // see RULE7

	// ----------------------------------------------------------------
	// fifo and shift pointers
	// ----------------------------------------------------------------
	logic [SRB_AW-1:0] wptr_q;
	logic [SRB_AW-1:0] rptr_q;
	logic [SRB_CNT_W-1:0] cnt_q;
	logic [SRB_CNT_W-1:0] cnt_d;
	logic [SRB_CNT_W-1:0] depth;
	logic full_q;
	logic empty_q;
	logic push;
	logic pop;
	logic adv_w;

	assign depth = srb_depth(cfg.wr_width);
	assign push = is_fifo & wr_tick & wr.en & ~full_q;
	assign pop = is_fifo & rd_tick & rd.en & ~empty_q;
	assign adv_w = push | (is_shift & wr_tick & wr.en);

	always_comb begin
		cnt_d = cnt_q;
		if (push & ~pop)
			cnt_d = cnt_q + 10'h001;
		else if (pop & ~push)
			cnt_d = cnt_q - 10'h001;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			wptr_q <= adv_w ? srb_wrap(wptr_q, depth) : wptr_q;
			rptr_q <= pop ? srb_wrap(rptr_q, depth) : rptr_q;
			cnt_q <= cnt_d;
			full_q <= cnt_d == depth;
			empty_q <= cnt_d == 10'h000;
		end
	end

	// ----------------------------------------------------------------
	// input registers
	// ----------------------------------------------------------------
	srb_wr_t wr_q;
	srb_wr_t wr_d;
	logic [SRB_AW-1:0] rd_addr_q;
	logic [SRB_AW-1:0] rd_addr_sel;
	logic rd_en_q;
	logic rd_en_sel;
	logic rd_pend_q;
	logic wr_ok;

	// rom never writes; a full fifo drops the word
	assign wr_ok = wr.en & ~is_rom & (~is_fifo | ~full_q);
	assign wr_d.en = wr_tick & wr_ok;
	assign wr_d.addr = (is_fifo | is_shift) ? wptr_q : wr.addr;
	assign wr_d.data = wr.data;
	assign wr_d.be = wr.be;

	assign rd_addr_sel = is_fifo ? rptr_q
		: (is_shift ? wptr_q : (is_sp ? wr.addr : rd.addr));
	assign rd_en_sel = is_fifo ? (rd.en & ~empty_q)
		: ((is_shift | is_sp) ? wr.en : rd.en);

	// write-side registers all load on one tick, and wr_q.en clears on the next cycle; see RULE6
	always_ff @(posedge clk_sys) begin
		if (rst | clr_in) begin
			wr_q <= '0; // see RULE9
		end else if (wr_tick) begin
			wr_q <= wr_d;
		end else begin
			wr_q.en <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst | clr_in) begin
			rd_addr_q <= '0; // see RULE9
			rd_en_q <= 1'b0;
		end else if (rd_tick) begin
			rd_addr_q <= rd_addr_sel;
			rd_en_q <= rd_en_sel;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_pend_q <= (rst | clr_in) ? 1'b0 : (rd_tick & rd_en_sel);
	end

	// ----------------------------------------------------------------
	// storage array
	// ----------------------------------------------------------------
	logic [SRB_ROW_W-1:0] mem_q [SRB_ROWS]; // see RULE1
	srb_place_t wp;
	srb_place_t rp;
	logic [SRB_ROW_W-1:0] rd_word;
	logic [SRB_ROW_W-1:0] rd_word_q;

	// parity columns are plain storage; lanes masked by byte enables
	assign wp = srb_place(cfg.wr_width, wr_q.addr, wr_q.data,
		wr_q.be); // see RULE14
	assign rp = srb_place(rd_w, rd_addr_q, '0, '1); // see RULE2
	assign rd_word = srb_extract(rd_w, rd_addr_q, mem_q[rp.row]);

	// reset doubles as configuration and loads the image; see RULE5
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int r = 0; r < SRB_ROWS; r++)
				mem_q[r] <= INIT_IMAGE[r * SRB_ROW_W +: SRB_ROW_W];
		end else if (wr_q.en) begin
			mem_q[wp.row] <= (mem_q[wp.row] & ~wp.mask)
				| (wp.val & wp.mask);
		end
	end

	// the array write and this sample share an edge, so a collision
	// sees the word as it stood before the write; see RULE13
	always_ff @(posedge clk_sys) begin
		if (rst | clr_in)
			rd_word_q <= '0;
		else if (rd_pend_q)
			rd_word_q <= rd_word;
	end

	// ----------------------------------------------------------------
	// output register and status
	// ----------------------------------------------------------------
	logic out_load;

	// read enable low holds the last word on the output
	assign out_load = out_tick & rd_en_q;

	srb_outreg u_outreg (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(out_load),
		.clr(clr_out), // see RULE10
		.bypass(cfg.out_bypass), // see RULE8
		.d(rd_word_q),
		.q(rd_data)
	);

	assign fifo_full = full_q;
	assign fifo_empty = empty_q;

endmodule : srb_ram

// ==== include/srb_pkg.sv ====
// package for the small simple dual-port ram block: sizes, modes, carriers
package srb_pkg;

	// ----------------------------------------------------------------
	// storage geometry
	// ----------------------------------------------------------------
	localparam int SRB_BITS = 576;
	localparam int SRB_ROWS = 32;
	localparam int SRB_ROW_W = 18;
	localparam int SRB_ROW_AW = 5;
	localparam int SRB_DATA_W = 16;
	localparam int SRB_BYTE_W = 8;
	localparam int SRB_LANE_W = 9;
	localparam int SRB_AW = 9;
	localparam int SRB_BE_W = 2;
	localparam int SRB_CNT_W = 10;

	// ----------------------------------------------------------------
	// configuration types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SRB_W1, SRB_W2, SRB_W4, SRB_W8, SRB_W9, SRB_W16, SRB_W18
	} srb_width_t;

	typedef enum logic [2:0] {
		SRB_MODE_SDP, SRB_MODE_SP, SRB_MODE_FIFO, SRB_MODE_ROM,
		SRB_MODE_SHIFT
	} srb_mode_t;

	typedef enum logic {SRB_CLK_A, SRB_CLK_B} srb_clk_sel_t;

	typedef struct packed {
		srb_mode_t mode;
		srb_width_t wr_width;
		srb_width_t rd_width;
		srb_clk_sel_t wr_clk;
		srb_clk_sel_t rd_clk;
		srb_clk_sel_t out_clk;
		logic out_bypass;
	} srb_cfg_t;

	typedef struct packed {
		logic en;
		logic [SRB_AW-1:0] addr;
		logic [SRB_ROW_W-1:0] data;
		logic [SRB_BE_W-1:0] be;
	} srb_wr_t;

	typedef struct packed {
		logic en;
		logic [SRB_AW-1:0] addr;
	} srb_rd_t;

	typedef struct packed {
		logic [SRB_ROW_AW-1:0] row;
		logic [SRB_ROW_W-1:0] mask;
		logic [SRB_ROW_W-1:0] val;
	} srb_place_t;

	// ----------------------------------------------------------------
	// width decoding
	// ----------------------------------------------------------------
	function automatic int srb_wbits(srb_width_t w);
		unique case (w)
			SRB_W1: return 1;
			SRB_W2: return 2;
			SRB_W4: return 4;
			SRB_W8: return 8;
			SRB_W9: return 9;
			SRB_W16: return 16;
			default: return 18;
		endcase
	endfunction : srb_wbits

	function automatic logic srb_parity(srb_width_t w);
		return (w == SRB_W9) || (w == SRB_W18);
	endfunction : srb_parity

	function automatic logic [SRB_CNT_W-1:0] srb_depth(srb_width_t w);
		int per;
		per = srb_parity(w) ? SRB_ROW_W / srb_wbits(w)
			: SRB_DATA_W / srb_wbits(w);
		return SRB_CNT_W'(per * SRB_ROWS);
	endfunction : srb_depth

	// physical bit of logical bit k in a row; the non-parity widths
	// skip the two parity columns so every non-parity organisation sees 16 bits
	function automatic int srb_phys(srb_width_t w, int k);
		if (srb_parity(w) || k < SRB_BYTE_W)
			return k;
		return k + 1;
	endfunction : srb_phys

	function automatic srb_place_t srb_place(srb_width_t w,
		logic [SRB_AW-1:0] a, logic [SRB_ROW_W-1:0] d,
		logic [SRB_BE_W-1:0] be);
		srb_place_t p;
		int n;
		int per;
		int slot;
		int ph;
		p = '0;
		n = srb_wbits(w);
		per = srb_parity(w) ? SRB_ROW_W / n : SRB_DATA_W / n;
		p.row = SRB_ROW_AW'(int'(a) / per);
		slot = int'(a) % per;
		for (int i = 0; i < SRB_ROW_W; i++) begin
			if (i < n) begin
				ph = srb_phys(w, slot * n + i);
				p.mask[ph] = be[ph / SRB_LANE_W];
				p.val[ph] = d[i];
			end
		end
		return p;
	endfunction : srb_place

	function automatic logic [SRB_ROW_W-1:0] srb_extract(srb_width_t w,
		logic [SRB_AW-1:0] a, logic [SRB_ROW_W-1:0] row);
		logic [SRB_ROW_W-1:0] r;
		int n;
		int per;
		int slot;
		r = '0;
		n = srb_wbits(w);
		per = srb_parity(w) ? SRB_ROW_W / n : SRB_DATA_W / n;
		slot = int'(a) % per;
		for (int i = 0; i < SRB_ROW_W; i++) begin
			if (i < n)
				r[i] = row[srb_phys(w, slot * n + i)];
		end
		return r;
	endfunction : srb_extract

	function automatic logic [SRB_AW-1:0] srb_wrap(logic [SRB_AW-1:0] p,
		logic [SRB_CNT_W-1:0] depth);
		if ({1'b0, p} == depth - 10'h001)
			return 9'h000;
		return p + 9'h001;
	endfunction : srb_wrap

endpackage : srb_pkg

// ==== test/srb_assertions.sv ====
// port checker for the small ram block
module srb_assertions
	import srb_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// configuration and block clocks
	input wire srb_pkg::srb_cfg_t cfg,
	input wire logic clk_a,
	input wire logic clk_b,
	input wire logic clr_out,
	// outputs
	input wire logic [srb_pkg::SRB_ROW_W-1:0] rd_data,
	input wire logic fifo_full,
	input wire logic fifo_empty
);
	// ----
	// output clock pin and checks
	// ----
	wire logic oclk = (cfg.out_clk == SRB_CLK_B) ? clk_b : clk_a;
	default clocking cb @(posedge clk_sys); endclocking

	reset_zero_a: assert property (rst |=> rd_data == '0)
		else $error("read data not zero after reset");
	reset_flags_a: assert property (rst |=> fifo_empty && !fifo_full)
		else $error("fifo flags wrong after reset");
	out_clear_a: assert property (disable iff (rst)
		clr_out |=> rd_data == '0) else $error("output clear late");
	// registered output moves only on an output tick, a clear or a reset
	out_tick_a: assert property (disable iff (rst)
		!cfg.out_bypass && $changed(rd_data) |-> $past(clr_out) ||
		$past(rst) || ($past(oclk) && !$past(oclk, 2)))
		else $error("read data moved without output tick");
	flag_excl_a: assert property (disable iff (rst)
		!(fifo_full && fifo_empty)) else $error("full and empty");
	full_fifo_only_a: assert property (disable iff (rst)
		cfg.mode != SRB_MODE_FIFO |-> !fifo_full)
		else $error("full outside fifo mode");
	width_w8_a: assert property (disable iff (rst)
		cfg.mode == SRB_MODE_SDP && cfg.rd_width == SRB_W8
		|-> rd_data[17:8] == '0) else $error("x8 upper bits set");
	width_w16_a: assert property (disable iff (rst)
		cfg.mode == SRB_MODE_SDP && cfg.rd_width == SRB_W16
		|-> rd_data[17:16] == '0) else $error("x16 upper bits set");
endmodule : srb_assertions

bind srb_ram srb_assertions u_srb_assertions (.clk_sys(clk_sys),
	.rst(rst), .cfg(cfg), .clk_a(clk_a), .clk_b(clk_b),
	.clr_out(clr_out), .rd_data(rd_data), .fifo_full(fifo_full),
	.fifo_empty(fifo_empty));

// ==== test/srb_ram_tb_top.sv ====
// testbench for the small ram block
module srb_ram_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import srb_pkg::*;
	// ----
	// signals
	// ----
	localparam logic [SRB_BITS-1:0] INIT = 576'h2AB;
	logic clk_sys, rst, run, clk_a, clk_b, clr_out, clr_in;
	logic fifo_full, fifo_empty;
	logic [17:0] rd_data;
	srb_cfg_t cfg;
	srb_wr_t wr;
	srb_rd_t rd;
	int bad_count, n_checks, cyc;

	srb_ram #(.INIT_IMAGE(INIT)) u_srb_ram (.clk_sys(clk_sys), .rst(rst),
		.cfg(cfg), .clk_a(clk_a), .clk_b(clk_b), .ce_a(1'b1),
		.ce_b(1'b1), .clr_in(clr_in), .clr_out(clr_out), .wr(wr),
		.rd(rd), .rd_data(rd_data), .fifo_full(fifo_full),
		.fifo_empty(fifo_empty));
	srb_user_model u_srb_user_model (.clk_sys(clk_sys), .run(run),
		.clk_a(clk_a), .clk_b(clk_b));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [17:0] got,
		input logic [17:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic start(input srb_cfg_t c);
		@(negedge clk_sys);
		rst = 1'b1;
		// the partner samples run on this same edge: no race
		run <= 1'b0;
		cfg = c;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		run <= 1'b1;
	endtask : start
	// n cycles cover exactly one tick of clk_a when n is 2
	task automatic wr_word(input logic [8:0] a, input logic [17:0] d,
		input logic [1:0] be, input int n);
		@(negedge clk_sys);
		wr = '{1'b1, a, d, be};
		repeat (n) @(negedge clk_sys);
		wr.en = 1'b0;
	endtask : wr_word
	task automatic rd_word(input logic [8:0] a, input logic [17:0] e,
		input string nm);
		@(negedge clk_sys);
		rd = '{1'b1, a};
		repeat (10) @(negedge clk_sys);
		rd.en = 1'b0;
		chk(nm, rd_data, e);
	endtask : rd_word
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			summarize();
		end
	end
	// ----
	// tests
	// ----
	initial begin
		rst = 1'b1;
		run = 1'b0;
		clr_out = 1'b0;
		clr_in = 1'b0;
		cfg = '0;
		wr = '0;
		rd = '0;
		start('{SRB_MODE_SDP, SRB_W16, SRB_W8, SRB_CLK_A, SRB_CLK_A,
			SRB_CLK_A, 1'b0});
		chk("rd_data", rd_data, 18'h00000);
		chk("empty", {17'h0, fifo_empty}, 18'h00001);
		rd_word(9'h000, 18'h000AB, "init");
		wr_word(9'h003, 18'h01234, 2'h3, 6);
		rd_word(9'h006, 18'h00034, "low byte");
		rd_word(9'h007, 18'h00012, "high byte");
		repeat (4) @(negedge clk_sys);
		clr_out = 1'b1;
		@(negedge clk_sys);
		clr_out = 1'b0;
		chk("cleared", rd_data, 18'h00000);
		wr_word(9'h004, 18'h0FFFF, 2'h1, 6);
		rd_word(9'h008, 18'h000FF, "lane0");
		rd_word(9'h009, 18'h00000, "lane1");
		$display("test mixed width done");
		start('{SRB_MODE_SDP, SRB_W16, SRB_W16, SRB_CLK_B, SRB_CLK_A,
			SRB_CLK_B, 1'b1});
		wr_word(9'h005, 18'h0BEEF, 2'h3, 6);
		rd_word(9'h005, 18'h0BEEF, "two clocks");
		clr_in = 1'b1;
		@(negedge clk_sys);
		clr_in = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("input clear", rd_data, 18'h00000);
		$display("test clocking done");
		start('{SRB_MODE_ROM, SRB_W8, SRB_W8, SRB_CLK_A, SRB_CLK_A,
			SRB_CLK_A, 1'b0});
		wr_word(9'h000, 18'h00000, 2'h3, 6);
		rd_word(9'h000, 18'h000AB, "rom");
		$display("test rom done");
		start('{SRB_MODE_SP, SRB_W8, SRB_W8, SRB_CLK_A, SRB_CLK_A,
			SRB_CLK_A, 1'b0});
		wr_word(9'h002, 18'h0005A, 2'h3, 2);
		wr_word(9'h002, 18'h000A5, 2'h3, 2);
		repeat (6) @(negedge clk_sys);
		chk("old data", rd_data, 18'h0005A);
		$display("test single port done");
		start('{SRB_MODE_FIFO, SRB_W16, SRB_W16, SRB_CLK_A, SRB_CLK_A,
			SRB_CLK_A, 1'b0});
		wr_word(9'h000, 18'h01111, 2'h3, 2);
		wr_word(9'h000, 18'h02222, 2'h3, 2);
		chk("fifo filled", {17'h0, fifo_empty}, 18'h00000);
		rd_word(9'h000, 18'h02222, "fifo order");
		chk("fifo drained", {17'h0, fifo_empty}, 18'h00001);
		$display("test fifo done");
		start('{SRB_MODE_SHIFT, SRB_W16, SRB_W16, SRB_CLK_A, SRB_CLK_A,
			SRB_CLK_A, 1'b0});
		wr_word(9'h000, 18'h00777, 2'h3, 2);
		repeat (4) @(negedge clk_sys);
		chk("shift out", rd_data, 18'h001AB);
		$display("test shift done");
		summarize();
	end
endmodule : srb_ram_tb_top

// ==== test/srb_user_model.sv ====
// model of the fabric logic that drives the block clock pins
module srb_user_model (
	// clock and run control
	input wire logic clk_sys,
	input wire logic run,
	// block clock pins
	output logic clk_a,
	output logic clk_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q;
	initial div_q = 2'h0;
	// clocks rest low between runs so the first rise is always seen
	always @(negedge clk_sys) begin
		div_q <= run ? div_q + 2'h1 : 2'h0;
	end
	assign clk_a = div_q[0];
	assign clk_b = div_q[1];
endmodule : srb_user_model
